/* imv_pkg.sv */
// Constants shared by the interrupt mask and vector block.
// Assumes word-indexed registers: the byte address is four times the index.
package imv_pkg;
	// Register indices, byte address = index * 4
	localparam logic [9:0]  IDX_CLR0     = 10'h0da;
	localparam logic [9:0]  IDX_CLR1     = 10'h0db;
	localparam logic [9:0]  IDX_CLR2     = 10'h0dc;
	localparam logic [9:0]  IDX_SOFT     = 10'h0de;
	localparam logic [9:0]  IDX_EN2      = 10'h0df;
	localparam logic [9:0]  IDX_EN0      = 10'h0e0;
	localparam logic [9:0]  IDX_EN1      = 10'h0e1;
	localparam logic [9:0]  IDX_VEC      = 10'h0e2;
	localparam logic [9:0]  IDX_IRQ_STAT = 10'h0e4;
	localparam logic [9:0]  IDX_IRQ_MASK = 10'h0e5;
	// Implemented source bits, {group2, group1, group0}
	localparam logic [23:0] IMPL_BITS    = 24'h77e0ff;
	localparam logic [7:0]  SOFT_IMPL    = 8'h80;
	localparam int          SOFT_BIT     = 7;
	// Port pin sources inside the 24-bit posted vector
	localparam int          GPIO0_BIT    = 4;
	localparam int          GPIO1_BIT    = 7;
	localparam int          GPIO2_BIT    = 20;
	localparam int          GPIO3_BIT    = 21;
	localparam int          GPIO4_BIT    = 22;
	localparam logic [23:0] GPIO_BITS    = 24'h700090;
	// Reset values
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [23:0] RST_SRC      = 24'h000000;
	localparam logic [1:0]  RST_ST       = 2'h0;
	// Vector encoding: base + priority index * step, zero when idle
	localparam logic [7:0]  VEC_BASE     = 8'h04;
	localparam logic [7:0]  VEC_STEP     = 8'h04;
	localparam logic [7:0]  VEC_NONE     = 8'h00;
	// Block interrupt status bits
	localparam int          ST_POST      = 0;
	localparam int          ST_TAKEN     = 1;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

/* imv_top.sv */
// Interrupt mask, software post and vector clear logic with an AXI4-Lite slave.
// Assumes source pulses and CPU signals share aclk; port pins are asynchronous.
// Summary of operation
// - A posted interrupt with mask bit zero never becomes pending.
// - Sources still post while their mask bit is zero.
// - Each mask bit gates only its own source.
// - Mask bit one turns a posted interrupt into a pending one.
// - Soft enable off: written one ignored, written zero clears posted bit.
// - Soft enable on: written zero ignored, written one posts the source.
// - Soft enable is bit 7 of register 0xDE, reset zero, rest reserved.
// - Register 0xDF enables port 4,3,2, ext input 2, counter wrap, capture one.
// - Register 0xE1 enables capture zero, interval timer, millisecond timer.
// - Register 0xE0 enables eight group zero sources, one unmasks.
// - Reading 0xE2 returns the vector of the highest priority pending source.
// - Any write to 0xE2 clears every pending interrupt.
// - Port pin interrupts post on edges, not levels.
// - A posted interrupt stays until taken or cleared by software.
// - Reading a clear register shows one per posted source.
// - Highest pending is selected; CPU takes it only with global enable set.
`timescale 1ns/1ps
module imv_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [23:0] src_pulse,
	input  wire logic [4:0]  gpio_pin,
	input  wire logic        global_irq_enable,
	input  wire logic        cpu_int_ack,
	output logic             cpu_irq_req,
	output logic [7:0]       cpu_vector,
	output logic             irq
);
	logic [23:0] posted_reg;
	logic [23:0] posted_next;
	logic [23:0] en_reg;
	logic        soft_en_reg;
	logic [23:0] pend;
	logic [23:0] set_all;
	logic [23:0] clr_all;
	logic [23:0] gpio_set;
	logic [23:0] grp_sel;
	logic [23:0] wd24;
	logic [4:0]  gp_s1_reg;
	logic [4:0]  gp_s2_reg;
	logic [4:0]  gp_s3_reg;
	logic [4:0]  gp_edge;
	logic [11:0] awaddr_reg;
	logic [7:0]  wdata_reg;
	logic        wlane_reg;
	logic        wr_do;
	logic        wr_lane;
	logic        vec_wr;
	logic [9:0]  wr_idx;
	logic [9:0]  rd_idx;
	logic        wr_ok;
	logic        rd_ok;
	logic [7:0]  rd_byte;
	logic [4:0]  cur_idx_reg;
	logic [5:0]  top_sel;
	logic        took;
	logic [1:0]  st_reg;
	logic [1:0]  st_mask_reg;

	// Lowest set bit wins; returns {found, index}
	function automatic logic [5:0] imv_first(input logic [23:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 23; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	// Register index decode, shared by the read and write paths
	function automatic logic imv_mapped(input logic [9:0] idx);
		return idx inside {imv_pkg::IDX_CLR0, imv_pkg::IDX_CLR1, imv_pkg::IDX_CLR2,
			imv_pkg::IDX_SOFT, imv_pkg::IDX_EN2, imv_pkg::IDX_EN0, imv_pkg::IDX_EN1,
			imv_pkg::IDX_VEC, imv_pkg::IDX_IRQ_STAT, imv_pkg::IDX_IRQ_MASK};
	endfunction

	// Port pins cross into aclk through two flops before edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gp_s1_reg <= 5'h00;
			gp_s2_reg <= 5'h00;
			gp_s3_reg <= 5'h00;
		end else begin
			gp_s1_reg <= gpio_pin;
			gp_s2_reg <= gp_s1_reg;
			gp_s3_reg <= gp_s2_reg;
		end
	end

	// Rising edges only, so a held level posts once
	assign gp_edge = gp_s2_reg & ~gp_s3_reg;

	// Write path decode: the held address and data act in one cycle
	assign wr_do   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_idx  = awaddr_reg[11:2];
	assign wr_ok   = imv_mapped(wr_idx);
	assign wr_lane = wr_do && wlane_reg;
	assign vec_wr  = wr_do && (wr_idx == imv_pkg::IDX_VEC); // Data and strobes are don't care
	assign rd_idx  = s_axi_araddr[11:2];
	assign rd_ok   = imv_mapped(rd_idx);
	assign wd24    = {3{wdata_reg}};
	assign grp_sel = {{8{wr_lane && wr_idx == imv_pkg::IDX_CLR2}},
		{8{wr_lane && wr_idx == imv_pkg::IDX_CLR1}},
		{8{wr_lane && wr_idx == imv_pkg::IDX_CLR0}}};

	// Each enable gates only its own posted bit
	assign pend    = posted_reg & en_reg;
	assign top_sel = imv_first(pend);
	assign took    = cpu_int_ack && cpu_irq_req;

	// Posting and clearing; a new event beats a clear in the same cycle
	always_comb begin
		gpio_set = imv_pkg::RST_SRC;
		gpio_set[imv_pkg::GPIO0_BIT] = gp_edge[0];
		gpio_set[imv_pkg::GPIO1_BIT] = gp_edge[1];
		gpio_set[imv_pkg::GPIO2_BIT] = gp_edge[2];
		gpio_set[imv_pkg::GPIO3_BIT] = gp_edge[3];
		gpio_set[imv_pkg::GPIO4_BIT] = gp_edge[4];
		// Sources post regardless of their enable
		set_all = (src_pulse & ~imv_pkg::GPIO_BITS | gpio_set) & imv_pkg::IMPL_BITS;
		clr_all = imv_pkg::RST_SRC;
		if (soft_en_reg) begin
			set_all = set_all | (grp_sel & wd24 & imv_pkg::IMPL_BITS);
		end else begin
			clr_all = grp_sel & ~wd24 & imv_pkg::IMPL_BITS;
		end
		if (vec_wr) begin
			clr_all = clr_all | pend;
		end
		if (took) begin
			clr_all[cur_idx_reg] = 1'b1;
		end
		posted_next = (posted_reg & ~clr_all) | set_all;
	end

	// Posted flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			posted_reg <= imv_pkg::RST_SRC;
		end else begin
			posted_reg <= posted_next;
		end
	end

	// Clear-register writes that must leave a flag alone, retirement by the CPU, and no repost from a held port level
	a_one_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane && wr_idx == imv_pkg::IDX_CLR1 && !soft_en_reg && wdata_reg[5] && !src_pulse[13] && !took)
		|=> (posted_reg[13] == $past(posted_reg[13])))
		else $error("one write without soft enable changed a flag");
	a_zero_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane && wr_idx == imv_pkg::IDX_CLR1 && soft_en_reg && !wdata_reg[5] && posted_reg[13] && !took)
		|=> posted_reg[13])
		else $error("zero write with soft enable cleared a flag");
	a_taken_retires: assert property (@(posedge aclk) disable iff (!aresetn)
		(took && cur_idx_reg == 5'h10 && !set_all[16])
		|=> !posted_reg[16])
		else $error("taken interrupt stayed posted");
	a_level_no_repost: assert property (@(posedge aclk) disable iff (!aresetn)
		(gp_s3_reg[0] && !posted_reg[imv_pkg::GPIO0_BIT] && !(soft_en_reg && grp_sel[imv_pkg::GPIO0_BIT]))
		|=> !posted_reg[imv_pkg::GPIO0_BIT])
		else $error("held port level posted again");

	// Enable registers; reserved bits never store
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_reg      <= imv_pkg::RST_SRC;
			soft_en_reg <= 1'b0;
		end else if (wr_lane) begin
			unique case (wr_idx)
				imv_pkg::IDX_SOFT: soft_en_reg <= wdata_reg[imv_pkg::SOFT_BIT];
				imv_pkg::IDX_EN0:  en_reg[7:0] <= wdata_reg & imv_pkg::IMPL_BITS[7:0];
				imv_pkg::IDX_EN1:  en_reg[15:8] <= wdata_reg & imv_pkg::IMPL_BITS[15:8];
				imv_pkg::IDX_EN2:  en_reg[23:16] <= wdata_reg & imv_pkg::IMPL_BITS[23:16];
				default: ;
			endcase
		end
	end

	// Enable stores; a reserved bit written as one must still read back zero
	a_soft_store: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane && wr_idx == imv_pkg::IDX_SOFT)
		|=> (soft_en_reg == $past(wdata_reg[imv_pkg::SOFT_BIT])))
		else $error("soft enable did not store bit 7");
	a_group2_store: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane && wr_idx == imv_pkg::IDX_EN2)
		|=> (en_reg[23:16] == ($past(wdata_reg) & 8'h77)))
		else $error("group two enables stored wrong bits");
	a_group1_store: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane && wr_idx == imv_pkg::IDX_EN1)
		|=> (en_reg[15:8] == ($past(wdata_reg) & 8'he0)))
		else $error("group one enables stored wrong bits");
	a_group0_store: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane && wr_idx == imv_pkg::IDX_EN0)
		|=> (en_reg[7:0] == $past(wdata_reg)))
		else $error("group zero enables stored wrong bits");
	a_mask_independent: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane && wr_idx == imv_pkg::IDX_EN0)
		|=> ($stable(en_reg[23:8]) && $stable(soft_en_reg)))
		else $error("group zero write disturbed another enable");

	// CPU side: request, vector and the index that an acknowledge retires
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_irq_req <= 1'b0;
			cpu_vector  <= imv_pkg::VEC_NONE;
			cur_idx_reg <= 5'h00;
		end else begin
			cpu_irq_req <= top_sel[5] && global_irq_enable;
			cpu_vector  <= top_sel[5] ? 8'(imv_pkg::VEC_BASE + {3'h0, top_sel[4:0]} * imv_pkg::VEC_STEP)
				: imv_pkg::VEC_NONE;
			cur_idx_reg <= top_sel[4:0];
		end
	end

	// Block status: sticky, write one to clear, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg      <= imv_pkg::RST_ST;
			st_mask_reg <= imv_pkg::RST_ST;
			irq         <= 1'b0;
		end else begin
			st_reg <= (st_reg & ~((wr_lane && wr_idx == imv_pkg::IDX_IRQ_STAT) ? wdata_reg[1:0] : 2'h0))
				| {took, |set_all};
			if (wr_lane && wr_idx == imv_pkg::IDX_IRQ_MASK) begin
				st_mask_reg <= wdata_reg[1:0];
			end
			irq <= |(st_reg & st_mask_reg);
		end
	end

	// The block interrupt follows unmasked status one edge later
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		((st_reg & st_mask_reg) != 2'h0) |=> irq)
		else $error("block interrupt low with unmasked status");

	// Write channel: address and data are taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= imv_pkg::RESP_OKAY;
			awaddr_reg    <= 12'h000;
			wdata_reg     <= imv_pkg::RST_BYTE;
			wlane_reg     <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awaddr_reg    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_reg    <= s_axi_wdata[7:0];
				wlane_reg    <= s_axi_wstrb[0];
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? imv_pkg::RESP_OKAY : imv_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read data select; clear registers show posted flags
	always_comb begin
		unique case (rd_idx)
			imv_pkg::IDX_CLR0:     rd_byte = posted_reg[7:0];
			imv_pkg::IDX_CLR1:     rd_byte = posted_reg[15:8];
			imv_pkg::IDX_CLR2:     rd_byte = posted_reg[23:16];
			imv_pkg::IDX_SOFT:     rd_byte = {soft_en_reg, 7'h00};
			imv_pkg::IDX_EN0:      rd_byte = en_reg[7:0];
			imv_pkg::IDX_EN1:      rd_byte = en_reg[15:8];
			imv_pkg::IDX_EN2:      rd_byte = en_reg[23:16];
			imv_pkg::IDX_VEC:      rd_byte = cpu_vector;
			imv_pkg::IDX_IRQ_STAT: rd_byte = {6'h00, st_reg};
			imv_pkg::IDX_IRQ_MASK: rd_byte = {6'h00, st_mask_reg};
			default:               rd_byte = imv_pkg::RST_BYTE;
		endcase
	end

	// Read channel: one read at a time, data one edge after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= imv_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, rd_byte};
			s_axi_rresp   <= rd_ok ? imv_pkg::RESP_OKAY : imv_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Read data must match the state it was taken from; an unmasked posted bit must reach the vector
	a_clear_reads_posted: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && rd_idx == imv_pkg::IDX_CLR2)
		|=> (s_axi_rdata[7:0] == $past(posted_reg[23:16])))
		else $error("clear register read did not show posted flags");
	a_vector_read: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && rd_idx == imv_pkg::IDX_VEC)
		|=> (s_axi_rdata[7:0] == $past(cpu_vector)))
		else $error("vector read did not return the shown vector");
	a_unmasked_pends: assert property (@(posedge aclk) disable iff (!aresetn)
		(posted_reg[3] && en_reg[3])
		|=> (cpu_vector != imv_pkg::VEC_NONE))
		else $error("unmasked posted source not pending");

	// Mask, post, vector and hold checks
	a_mask_blocks_req: assert property (@(posedge aclk) disable iff (!aresetn)
		(pend == 24'h000000) |=> !cpu_irq_req)
		else $error("request raised with nothing pending");
	a_post_when_masked: assert property (@(posedge aclk) disable iff (!aresetn)
		(src_pulse[0] && !en_reg[0]) |=> posted_reg[0])
		else $error("masked source failed to post");
	a_clear_by_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane && wr_idx == imv_pkg::IDX_CLR0 && !soft_en_reg && !wdata_reg[1] && !src_pulse[1])
		|=> !posted_reg[1])
		else $error("zero write did not clear posted flag");
	a_soft_post_one: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane && wr_idx == imv_pkg::IDX_CLR1 && soft_en_reg && wdata_reg[6]) |=> posted_reg[14])
		else $error("one write with soft enable did not post");
	a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(en_reg & ~imv_pkg::IMPL_BITS) == 24'h000000 && (posted_reg & ~imv_pkg::IMPL_BITS) == 24'h000000)
		else $error("reserved bit stored");
	a_idle_vector_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(pend == 24'h000000) |=> (cpu_vector == 8'h00))
		else $error("vector nonzero while idle");
	a_vector_lowest: assert property (@(posedge aclk) disable iff (!aresetn)
		pend[0] |=> (cpu_vector == 8'h04))
		else $error("top source gave wrong vector");
	a_vec_write_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		(vec_wr && set_all == 24'h000000) |=> ((posted_reg & $past(en_reg)) == 24'h000000))
		else $error("vector write left pending interrupts");
	a_gpio_edge_post: assert property (@(posedge aclk) disable iff (!aresetn)
		(gp_s2_reg[0] && !gp_s3_reg[0]) |=> posted_reg[imv_pkg::GPIO0_BIT])
		else $error("port edge did not post");
	a_posted_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(posted_reg[3]) |-> $past(clr_all[3]))
		else $error("posted flag dropped without a clear");
	a_req_needs_gie: assert property (@(posedge aclk) disable iff (!aresetn)
		cpu_irq_req |-> $past(global_irq_enable))
		else $error("request raised without global enable");
endmodule

/* imv_cpu_model.sv */
// CPU core model on the far side of the interrupt link.
// Assumes the block's aclk and aresetn; the bench decides whether the core will take interrupts.
`timescale 1ns/1ps
module imv_cpu_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       take_en,
	input  wire logic       cpu_irq_req,
	input  wire logic [7:0] cpu_vector,
	output logic            global_irq_enable,
	output logic            cpu_int_ack,
	output logic [7:0]      taken_vec
);
	logic [1:0] hold_reg;

	// Global enable drops during a dispatch, as the real core clears it when it takes one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_irq_enable <= 1'b0;
		end else begin
			global_irq_enable <= take_en && (hold_reg == 2'h0) && !cpu_int_ack;
		end
	end

	// One-cycle ack, then a pause so the next take sees an updated vector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_int_ack <= 1'b0;
			hold_reg    <= 2'h0;
			taken_vec   <= 8'h00;
		end else begin
			cpu_int_ack <= 1'b0;
			if (hold_reg != 2'h0) begin
				hold_reg <= hold_reg - 2'h1;
			end else if (cpu_irq_req && global_irq_enable) begin
				cpu_int_ack <= 1'b1;
				taken_vec   <= cpu_vector;
				hold_reg    <= 2'h3;
			end
		end
	end
endmodule

/* testbench.sv */
// Self-checking bench for the interrupt mask and vector block.
// Assumes imv_pkg, imv_top and the CPU model; the bench is the AXI4-Lite master and the sources.
`timescale 1ns/1ps
module testbench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        global_irq_enable, cpu_int_ack, cpu_irq_req, irq, take_en;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [23:0] src_pulse;
	logic [4:0]  gpio_pin;
	logic [7:0]  cpu_vector, taken_vec;
	int          errors, checks_done;

	imv_top imv_top_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.src_pulse, .gpio_pin, .global_irq_enable, .cpu_int_ack, .cpu_irq_req, .cpu_vector, .irq
	);

	imv_cpu_model imv_cpu_model_inst (
		.aclk, .aresetn, .take_en, .cpu_irq_req, .cpu_vector, .global_irq_enable, .cpu_int_ack, .taken_vec
	);

	// Clock at 250 MHz
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// Verdict and timeout exit
	task automatic print_verdict();
		if (errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic hang();
		errors++;
		print_verdict();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Only the hole below the soft enable register is left unmapped in these scenarios
	function automatic logic [1:0] rsp(input logic [9:0] i);
		return (i == 10'h0dd) ? imv_pkg::RESP_SLVERR : imv_pkg::RESP_OKAY;
	endfunction

	function automatic logic [7:0] vexp(input int b);
		return imv_pkg::VEC_BASE + imv_pkg::VEC_STEP * 8'(b);
	endfunction

	// Write; each channel is released at the edge that takes it, an edge passes before the next use
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		s_axi_bready <= 1'b0;
		if (n >= 50) hang();
		chk({30'h0, s_axi_bresp}, {30'h0, rsp(i)});
	endtask

	// Read after a short settle, since the vector register lags the pending logic
	task automatic rd(input logic [9:0] i, input logic [7:0] e);
		int n;
		repeat (4) @(posedge aclk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		s_axi_rready <= 1'b0;
		if (n >= 50) hang();
		chk(s_axi_rdata, {24'h000000, e});
		chk({30'h0, s_axi_rresp}, {30'h0, rsp(i)});
	endtask

	task automatic pulse(input int b);
		src_pulse <= 24'h000001 << b;
		@(posedge aclk);
		src_pulse <= 24'h000000;
		repeat (3) @(posedge aclk);
	endtask

	task automatic t_reset();
		rd(imv_pkg::IDX_SOFT, 8'h00);
		rd(imv_pkg::IDX_EN2, 8'h00);
		rd(imv_pkg::IDX_EN1, 8'h00);
		rd(imv_pkg::IDX_EN0, 8'h00);
		rd(imv_pkg::IDX_VEC, 8'h00);
		rd(10'h0dd, 8'h00);
	endtask

	// Reserved bits read back zero; the unmapped write must be refused
	task automatic t_regs();
		wr(imv_pkg::IDX_SOFT, 8'hff);
		wr(imv_pkg::IDX_EN2, 8'hff);
		wr(imv_pkg::IDX_EN1, 8'hff);
		wr(imv_pkg::IDX_EN0, 8'hff);
		wr(10'h0dd, 8'hff);
		rd(imv_pkg::IDX_SOFT, 8'h80);
		rd(imv_pkg::IDX_EN2, 8'h77);
		rd(imv_pkg::IDX_EN1, 8'he0);
		rd(imv_pkg::IDX_EN0, 8'hff);
		wr(imv_pkg::IDX_SOFT, 8'h00);
		wr(imv_pkg::IDX_EN2, 8'h00);
		wr(imv_pkg::IDX_EN1, 8'h00);
		wr(imv_pkg::IDX_EN0, 8'h00);
		// A write with byte lane zero disabled stores nothing
		s_axi_wstrb <= 4'h0;
		wr(imv_pkg::IDX_EN0, 8'hff);
		s_axi_wstrb <= 4'h1;
		rd(imv_pkg::IDX_EN0, 8'h00);
	endtask

	task automatic t_mask();
		pulse(3);
		pulse(0);
		rd(imv_pkg::IDX_CLR0, 8'h09);
		rd(imv_pkg::IDX_VEC, 8'h00);
		wr(imv_pkg::IDX_EN0, 8'h08);
		rd(imv_pkg::IDX_VEC, vexp(3));
		wr(imv_pkg::IDX_EN0, 8'h09);
		rd(imv_pkg::IDX_VEC, vexp(0));
	endtask

	// A masked posted bit is not pending, so the vector write leaves it
	task automatic t_vec();
		pulse(1);
		wr(imv_pkg::IDX_VEC, 8'h5a);
		rd(imv_pkg::IDX_CLR0, 8'h02);
		rd(imv_pkg::IDX_VEC, 8'h00);
		wr(imv_pkg::IDX_CLR0, 8'h00);
		rd(imv_pkg::IDX_CLR0, 8'h00);
	endtask

	task automatic t_soft();
		wr(imv_pkg::IDX_CLR1, 8'hff);
		rd(imv_pkg::IDX_CLR1, 8'h00);
		wr(imv_pkg::IDX_SOFT, 8'h80);
		wr(imv_pkg::IDX_CLR1, 8'hff);
		wr(imv_pkg::IDX_CLR2, 8'hff);
		wr(imv_pkg::IDX_CLR1, 8'h00);
		rd(imv_pkg::IDX_CLR1, 8'he0);
		rd(imv_pkg::IDX_CLR2, 8'h77);
		wr(imv_pkg::IDX_SOFT, 8'h00);
		wr(imv_pkg::IDX_CLR1, 8'h7f);
		wr(imv_pkg::IDX_CLR2, 8'h00);
		rd(imv_pkg::IDX_CLR1, 8'h60);
		rd(imv_pkg::IDX_CLR2, 8'h00);
		wr(imv_pkg::IDX_CLR1, 8'h00);
	endtask

	// A held pin level must not post again once cleared
	task automatic t_gpio();
		gpio_pin <= 5'h11;
		repeat (5) @(posedge aclk);
		rd(imv_pkg::IDX_CLR0, 8'h10);
		rd(imv_pkg::IDX_CLR2, 8'h40);
		wr(imv_pkg::IDX_CLR0, 8'h00);
		wr(imv_pkg::IDX_CLR2, 8'h00);
		rd(imv_pkg::IDX_CLR0, 8'h00);
		gpio_pin <= 5'h00;
		rd(imv_pkg::IDX_CLR2, 8'h00);
	endtask

	task automatic t_take();
		int n;
		wr(imv_pkg::IDX_EN2, 8'h01);
		pulse(16);
		chk({31'h0, cpu_irq_req}, 32'h0);
		take_en <= 1'b1;
		n = 0;
		while (cpu_int_ack !== 1'b1 && n < 50) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 50) hang();
		take_en <= 1'b0;
		rd(imv_pkg::IDX_CLR2, 8'h00);
		chk({24'h0, taken_vec}, {24'h0, vexp(16)});
		chk({31'h0, cpu_irq_req}, 32'h0);
	endtask

	// Block interrupt: sticky status, mask, write-one-to-clear; the take above left the taken bit set
	task automatic t_irq();
		wr(imv_pkg::IDX_IRQ_MASK, 8'h02);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		wr(imv_pkg::IDX_IRQ_MASK, 8'h01);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		wr(imv_pkg::IDX_IRQ_STAT, 8'h03);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		pulse(2);
		chk({31'h0, irq}, 32'h1);
		wr(imv_pkg::IDX_IRQ_MASK, 8'h00);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
	endtask

	// Main sequence
	initial begin
		errors = 0;
		checks_done = 0;
		s_axi_wstrb = 4'h1;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, take_en} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, src_pulse, gpio_pin} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_regs();
		t_mask();
		t_vec();
		t_soft();
		t_gpio();
		t_take();
		t_irq();
		print_verdict();
	end
endmodule
